// >>> hw/dcw_interp.sv
// Fieldbus control word interpreter: decodes the 16-bit word into drive commands.
// Assumes the word and all status inputs are synchronous to I_SYS_CLK.
`timescale 1ns/1ns
module dcw_interp (
  // Clock and reset
  input  wire logic                          I_SYS_CLK,
  input  wire logic                          I_RST,
  // Fieldbus word
  input  wire logic [dcw_pkg::CW_W-1:0]      I_FIELDBUS_COMMAND_WORD,
  input  wire logic                          I_WORD_VALID,
  // Settings
  input  wire logic [1:0]                    I_CONTROL_PLACE_SELECT,
  input  wire logic [dcw_pkg::WD_SET_W-1:0]  I_LINK_WATCHDOG_TIMEOUT_SETTING,
  input  wire logic                          I_QSTOP_IS_COAST,
  input  wire logic                          I_STOP_IS_COAST,
  // Drive status and I/O
  input  wire logic                          I_AT_ZERO_SPEED,
  input  wire logic                          I_FAULT_ACTIVE,
  input  wire logic                          I_FAULT_CUTS_VOLTAGE,
  input  wire logic                          I_IO_JOG1,
  input  wire logic                          I_IO_JOG2,
  input  wire logic                          I_IO_JOG_ENABLE,
  input  wire logic                          I_PLACE_START,
  // Drive commands
  output logic [2:0]                         O_DRIVE_STATE,
  output logic                               O_POWER_ON,
  output logic                               O_RUN,
  output logic [1:0]                         O_STOP_MODE,
  output logic [1:0]                         O_RAMP_MODE,
  output logic                               O_JOG1,
  output logic                               O_JOG2,
  output logic                               O_FAULT_RESET,
  output logic                               O_FB_CONTROL_ACTIVE,
  output logic                               O_COMM_FAULT,
  output logic                               O_STATUS_WDOG
);
  import dcw_pkg::*;

  typedef struct packed {
    logic [CW_W-1:0]     prev;
    dcw_state_t          state;
    logic                power_on;
    logic                run;
    dcw_stop_t           stop;
    dcw_ramp_t           ramp;
    logic                jog1;
    logic                jog2;
    logic                jog_lock;
    logic                fault_reset;
    logic                fb_active;
    logic                comm_fault;
    logic                wd_echo;
    logic [WD_PRE_W-1:0] wd_pre;
    logic [WD_SET_W-1:0] wd_ms;
  } dcw_regs_t;

  // Ramp output held at zero from reset until the drive runs
  localparam dcw_regs_t REGS_RESET = '{
    prev:        CW_RESET,
    state:       ST_INHIBIT,
    power_on:    1'b0,
    run:         1'b0,
    stop:        STOP_NONE,
    ramp:        RAMP_ZERO_OUT,
    jog1:        1'b0,
    jog2:        1'b0,
    jog_lock:    1'b0,
    fault_reset: 1'b0,
    fb_active:   1'b0,
    comm_fault:  1'b0,
    wd_echo:     1'b0,
    wd_pre:      '0,
    wd_ms:       '0
  };

  dcw_regs_t       regs_reg;
  dcw_regs_t       regs_next;
  logic [CW_W-1:0] cw;
  logic            place_fb;
  logic            on_rise;
  logic            ack_rise;
  logic            fb_jog_req;
  logic            io_jog_req;
  logic            jog_both;
  // Decoded requests
  logic            coast_req;
  logic            qstop_req;
  logic            off_req;
  logic            start_req;
  logic            rearm_req;
  logic            fb_lost;
  logic            ramp_bits_low;
  logic            fb_jog_both;
  logic            io_jog_both;
  logic            wd_toggle;
  logic            wd_tick;
  logic            wd_expired;

  // ==========================================================================
  // Word qualification
  always_comb begin
    cw         = I_FIELDBUS_COMMAND_WORD & CW_USED_MASK;
    place_fb   = (I_CONTROL_PLACE_SELECT == PLACE_FIELDBUS);
    // Edges compare against the stored word, so a held valid repeats no edge
    on_rise    = I_WORD_VALID && cw[BIT_ON] && !regs_reg.prev[BIT_ON];
    ack_rise   = I_WORD_VALID && cw[BIT_FAULT_ACK] && !regs_reg.prev[BIT_FAULT_ACK];
    // Levels act on the stored word, one cycle after it lands
    coast_req  = regs_reg.fb_active && !regs_reg.prev[BIT_NO_COAST];
    qstop_req  = regs_reg.fb_active && !regs_reg.prev[BIT_NO_QSTOP];
    off_req    = regs_reg.fb_active && !regs_reg.prev[BIT_ON];
    start_req  = regs_reg.fb_active && regs_reg.prev[BIT_START];
    rearm_req  = regs_reg.fb_active && on_rise;
    // Jog from fieldbus: start high and all ramp bits low
    ramp_bits_low = !regs_reg.prev[BIT_RAMP_EN] && !regs_reg.prev[BIT_RAMP_RUN] && !regs_reg.prev[BIT_SP_EN];
    fb_jog_req = start_req && ramp_bits_low;
    io_jog_req = I_IO_JOG_ENABLE && (I_IO_JOG1 || I_IO_JOG2) && !I_PLACE_START;
    fb_lost    = !regs_reg.fb_active && regs_reg.state == ST_RUNNING && !io_jog_req;
    fb_jog_both = fb_jog_req && regs_reg.prev[BIT_JOG1] && regs_reg.prev[BIT_JOG2];
    io_jog_both = io_jog_req && I_IO_JOG1 && I_IO_JOG2;
    jog_both   = fb_jog_both || io_jog_both;
    // Watchdog: a toggle restarts the count; the tick is the 1 ms enable of the prescaler
    wd_toggle  = I_WORD_VALID && (cw[BIT_WDOG] != regs_reg.prev[BIT_WDOG]);
    wd_tick    = (regs_reg.wd_pre == WD_PRE_W'(WD_UNIT_CYC - 1));
    wd_expired = wd_tick && (regs_reg.wd_ms >= I_LINK_WATCHDOG_TIMEOUT_SETTING);
  end

  // ==========================================================================
  // Next-state logic
  always_comb begin
    regs_next             = regs_reg;
    regs_next.fault_reset = 1'b0;
    if (I_WORD_VALID) begin
      regs_next.prev = cw;
    end

    // ==========================================================================
    // Watchdog supervision
    // Echo follows every received word; supervision only when a timeout is set
    // Resolution is one tick: the fault comes one tick after the set time runs out
    regs_next.wd_echo = regs_next.prev[BIT_WDOG];
    if (I_LINK_WATCHDOG_TIMEOUT_SETTING == WD_OFF) begin
      regs_next.wd_pre = '0;
      regs_next.wd_ms  = '0;
    end else if (wd_toggle) begin
      regs_next.wd_pre = '0;
      regs_next.wd_ms  = '0;
    end else if (wd_tick) begin
      regs_next.wd_pre = '0;
      if (wd_expired) begin
        regs_next.comm_fault = 1'b1;
      end else begin
        regs_next.wd_ms = regs_reg.wd_ms + 1'b1;
      end
    end else begin
      regs_next.wd_pre = regs_reg.wd_pre + 1'b1;
    end

    // Control ownership
    regs_next.fb_active = place_fb && regs_next.prev[BIT_FB_EN];

    // Fault acknowledge clears the link fault too, except in a wd_tick cycle; a new loss sets it again
    if (ack_rise && regs_reg.fb_active) begin
      regs_next.fault_reset = 1'b1;
      if (!wd_tick) begin
        regs_next.comm_fault = 1'b0;
      end
    end

    // ==========================================================================
    // Drive state machine
    unique case (regs_reg.state)
      ST_INHIBIT: begin
        if (rearm_req) begin
          regs_next.state = ST_READY_RUN;
        end
      end
      ST_READY_ON, ST_READY_RUN, ST_RUNNING: begin
        if (fb_lost) begin
          regs_next.state = ST_INHIBIT;
          regs_next.stop  = STOP_COAST;
        end else if (coast_req) begin
          regs_next.state = ST_INHIBIT;
          regs_next.stop  = STOP_COAST;
        end else if (qstop_req) begin
          regs_next.state = ST_INHIBIT;
          regs_next.stop  = I_QSTOP_IS_COAST ? STOP_COAST : STOP_QUICK;
        end else if (regs_reg.state == ST_READY_ON && rearm_req) begin
          // Ahead of the off request: a rising edge always follows a stored low bit
          regs_next.state = ST_READY_RUN;
        end else if (off_req) begin
          regs_next.state = ST_READY_ON;
          regs_next.stop  = STOP_RAMP;
        end else if (regs_reg.state != ST_READY_ON && (start_req || io_jog_req)) begin
          regs_next.state = ST_RUNNING;
          regs_next.stop  = STOP_NONE;
        end else if (regs_reg.state == ST_RUNNING) begin
          regs_next.state = ST_READY_RUN;
          regs_next.stop  = I_STOP_IS_COAST ? STOP_COAST : STOP_RAMP;
        end
      end
      ST_FAULT: begin
        if (regs_next.fault_reset) begin
          regs_next.state = I_FAULT_CUTS_VOLTAGE ? ST_INHIBIT : ST_READY_RUN;
        end
      end
    endcase
    if (I_FAULT_ACTIVE || regs_next.comm_fault) begin
      regs_next.state = ST_FAULT;
      regs_next.stop  = STOP_COAST;
    end

    // Power follows the control held when the state was decided, so a lost
    // enable drops power together with the coast stop that it causes
    regs_next.power_on = (regs_next.state == ST_READY_RUN || regs_next.state == ST_RUNNING)
                         && (regs_reg.fb_active || io_jog_req);
    regs_next.run = (regs_next.state == ST_RUNNING);

    // ==========================================================================
    // Jog and ramp control
    // Jog latches at zero speed or while the lock is held; the lock keeps ramp bits out until zero speed again
    if (regs_next.run && !jog_both && (fb_jog_req || io_jog_req)
        && (regs_reg.jog_lock || I_AT_ZERO_SPEED)) begin
      regs_next.jog_lock = 1'b1;
      regs_next.jog1 = fb_jog_req ? regs_reg.prev[BIT_JOG1] : I_IO_JOG1;
      regs_next.jog2 = fb_jog_req ? regs_reg.prev[BIT_JOG2] : I_IO_JOG2;
    end else begin
      regs_next.jog1 = 1'b0;
      regs_next.jog2 = 1'b0;
      if (I_AT_ZERO_SPEED) begin
        regs_next.jog_lock = 1'b0;
      end
    end
    // Both jog bits at once drop both references and ask for a ramped stop
    if (jog_both) begin
      regs_next.stop = STOP_RAMP;
    end

    // Jog owns the reference, so ramp bits wait until the lock clears
    if (!regs_next.run || regs_next.jog_lock) begin
      regs_next.ramp = RAMP_ZERO_OUT;
    end else if (!regs_reg.prev[BIT_RAMP_EN]) begin
      regs_next.ramp = RAMP_ZERO_OUT;
    end else if (!regs_reg.prev[BIT_RAMP_RUN]) begin
      regs_next.ramp = RAMP_HOLD;
    end else if (!regs_reg.prev[BIT_SP_EN]) begin
      regs_next.ramp = RAMP_ZERO_IN;
    end else begin
      regs_next.ramp = RAMP_FOLLOW;
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      regs_reg <= REGS_RESET;
    end else begin
      regs_reg <= regs_next;
    end
  end

  // ==========================================================================
  // Outputs
  // Every output is a register field; nothing combinational reaches a pin
  always_comb begin
    O_DRIVE_STATE       = regs_reg.state;
    O_POWER_ON          = regs_reg.power_on;
    O_RUN               = regs_reg.run;
    O_STOP_MODE         = regs_reg.stop;
    O_RAMP_MODE         = regs_reg.ramp;
    O_JOG1              = regs_reg.jog1;
    O_JOG2              = regs_reg.jog2;
    O_FAULT_RESET       = regs_reg.fault_reset;
    O_FB_CONTROL_ACTIVE = regs_reg.fb_active;
    O_COMM_FAULT        = regs_reg.comm_fault;
    O_STATUS_WDOG       = regs_reg.wd_echo;
  end
endmodule : dcw_interp

// >>> hw/dcw_pkg.sv
// Constants and types for the drive control word interpreter.
// Assumes one 20 MHz control clock shared by all users of this package.
package dcw_pkg;
  // ==========================================================================
  // Control word bit positions
  localparam int unsigned CW_W          = 16;
  localparam int unsigned BIT_ON        = 0;
  localparam int unsigned BIT_NO_COAST  = 1;
  localparam int unsigned BIT_NO_QSTOP  = 2;
  localparam int unsigned BIT_START     = 3;
  localparam int unsigned BIT_RAMP_EN   = 4;
  localparam int unsigned BIT_RAMP_RUN  = 5;
  localparam int unsigned BIT_SP_EN     = 6;
  localparam int unsigned BIT_FAULT_ACK = 7;
  localparam int unsigned BIT_JOG1      = 8;
  localparam int unsigned BIT_JOG2      = 9;
  localparam int unsigned BIT_FB_EN     = 10;
  localparam int unsigned BIT_WDOG      = 11;
  localparam logic [CW_W-1:0] CW_USED_MASK = 16'h0FFF;
  localparam logic [CW_W-1:0] CW_RESET     = 16'h0000;
  // ==========================================================================
  // Control place, timing and widths
  localparam logic [1:0] PLACE_FIELDBUS = 2'h3;
  localparam int unsigned CLK_HZ   = 20_000_000;
  localparam int unsigned WD_UNIT_MS = 1;
  localparam int unsigned WD_UNIT_CYC = CLK_HZ / 1000 * WD_UNIT_MS;
  localparam int unsigned WD_SET_W = 16;
  localparam int unsigned WD_PRE_W = 16;
  localparam logic [WD_SET_W-1:0] WD_OFF = 16'h0000;
  localparam int unsigned STAT_WDOG_BIT = 15;
  // ==========================================================================
  // Drive states, ramp and stop commands
  typedef enum logic [2:0] {
    ST_INHIBIT, ST_READY_ON, ST_READY_RUN, ST_RUNNING, ST_FAULT
  } dcw_state_t;
  typedef enum logic [1:0] {
    RAMP_FOLLOW, RAMP_ZERO_OUT, RAMP_HOLD, RAMP_ZERO_IN
  } dcw_ramp_t;
  typedef enum logic [1:0] {
    STOP_NONE, STOP_RAMP, STOP_COAST, STOP_QUICK
  } dcw_stop_t;
endpackage : dcw_pkg

// >>> bench/dcw_interp_properties.sv
// Port-level checks for the control word interpreter.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ns
module dcw_interp_properties
  import dcw_pkg::*;
(
  // Clock, reset, word, settings and status
  input wire logic                     I_SYS_CLK,
  input wire logic                     I_RST,
  input wire logic [CW_W-1:0]          I_FIELDBUS_COMMAND_WORD,
  input wire logic                     I_WORD_VALID,
  input wire logic [1:0]               I_CONTROL_PLACE_SELECT,
  input wire logic [WD_SET_W-1:0]      I_LINK_WATCHDOG_TIMEOUT_SETTING,
  input wire logic                     I_AT_ZERO_SPEED,
  // Drive commands
  input wire logic [2:0]               O_DRIVE_STATE,
  input wire logic                     O_POWER_ON,
  input wire logic                     O_RUN,
  input wire logic [1:0]               O_STOP_MODE,
  input wire logic                     O_JOG1,
  input wire logic                     O_JOG2,
  input wire logic                     O_FAULT_RESET,
  input wire logic                     O_FB_CONTROL_ACTIVE,
  input wire logic                     O_COMM_FAULT,
  input wire logic                     O_STATUS_WDOG
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  // ==========================================================================
  // Properties
  a_wdog_echo: assert property (
    I_WORD_VALID |=> O_STATUS_WDOG == $past(I_FIELDBUS_COMMAND_WORD[BIT_WDOG])) else $error("echo wrong");
  a_fb_enable: assert property (
    I_WORD_VALID |=> O_FB_CONTROL_ACTIVE == ($past(I_FIELDBUS_COMMAND_WORD[BIT_FB_EN])
      && $past(I_CONTROL_PLACE_SELECT) == PLACE_FIELDBUS)) else $error("fb control flag wrong");
  a_run_powered: assert property (
    O_RUN |-> O_POWER_ON && O_DRIVE_STATE == ST_RUNNING) else $error("run without power");
  a_rearm_path: assert property (
    $past(O_DRIVE_STATE) == ST_INHIBIT && O_DRIVE_STATE != ST_INHIBIT
      |-> O_DRIVE_STATE inside {ST_READY_RUN, ST_FAULT}) else $error("bad exit from inhibit");
  a_ack_pulse: assert property (
    O_FAULT_RESET |=> !O_FAULT_RESET) else $error("fault reset too long");
  a_jog_single: assert property (
    !(O_JOG1 && O_JOG2)) else $error("both jogs selected");
  a_jog_at_zero: assert property (
    $rose(O_JOG1) || $rose(O_JOG2) |-> $past(I_AT_ZERO_SPEED) || $past(I_AT_ZERO_SPEED, 2)
      || $past(I_AT_ZERO_SPEED, 3)) else $error("jog granted while moving");
  a_coast_on_loss: assert property (
    $fell(O_FB_CONTROL_ACTIVE) && O_RUN
      |-> ##[1:3] (O_DRIVE_STATE == ST_INHIBIT && O_STOP_MODE == STOP_COAST)) else $error("no coast on loss");
  a_wd_off_quiet: assert property (
    I_LINK_WATCHDOG_TIMEOUT_SETTING == WD_OFF && $past(I_LINK_WATCHDOG_TIMEOUT_SETTING) == WD_OFF
      |-> !$rose(O_COMM_FAULT)) else $error("watchdog fault while off");
  a_comm_fault: assert property (
    $rose(O_COMM_FAULT) |-> ##[0:2] O_DRIVE_STATE == ST_FAULT) else $error("comm fault not entered");
endmodule : dcw_interp_properties
bind dcw_interp dcw_interp_properties u_props (.I_SYS_CLK, .I_RST, .I_FIELDBUS_COMMAND_WORD, .I_WORD_VALID,
  .I_CONTROL_PLACE_SELECT, .I_LINK_WATCHDOG_TIMEOUT_SETTING, .I_AT_ZERO_SPEED, .O_DRIVE_STATE, .O_POWER_ON,
  .O_RUN, .O_STOP_MODE, .O_JOG1, .O_JOG2, .O_FAULT_RESET, .O_FB_CONTROL_ACTIVE, .O_COMM_FAULT, .O_STATUS_WDOG);

// >>> bench/dcw_master_model.sv
// Fieldbus master model: hands over one control word per call.
// Assumes calls start just after a clock edge of i_clk.
`timescale 1ns/1ns
module dcw_master_model (
  input  wire logic        i_clk,
  output logic [15:0]      o_word,
  output logic             o_valid
);
  initial begin
    o_word  = 16'h0000;
    o_valid = 1'h0;
  end
  // Caller orders the words; one whole word per valid
  task automatic send(input logic [15:0] w);
    @(posedge i_clk);
    o_word  <= w;
    o_valid <= 1'h1;
    @(posedge i_clk);
    o_valid <= 1'h0;
    // Released bus shows the inverse so stale data never looks valid
    o_word  <= ~w;
  endtask : send
endmodule : dcw_master_model

// >>> bench/tb_top.sv
// Self-checking bench for the control word interpreter.
// Assumes the package, design, checker and master model are compiled first.
`timescale 1ns/1ns
module tb_top;
  import dcw_pkg::*;
  logic clk = 1'h0, rst = 1'h1, zspd = 1'h1, fact = 1'h0, fcut = 1'h1, stc = 1'h0;
  logic [1:0]  place = 2'h3;
  logic [15:0] wds = 16'h0000, word;
  logic vld, pwr, run, jog1, jog2, frst, fba, cflt, wdog;
  logic [2:0]  state;
  logic [1:0]  stopm, rampm;
  logic [3:0]  nrst = 4'h0;
  logic        echo_q[$];
  int miscompares = 0, checks_done = 0, seed = 19, cyc = 0, i;
  dcw_master_model mdl (.i_clk(clk), .o_word(word), .o_valid(vld));
  dcw_interp dut (.I_SYS_CLK(clk), .I_RST(rst), .I_FIELDBUS_COMMAND_WORD(word), .I_WORD_VALID(vld),
    .I_CONTROL_PLACE_SELECT(place), .I_LINK_WATCHDOG_TIMEOUT_SETTING(wds), .I_QSTOP_IS_COAST(1'h0),
    .I_STOP_IS_COAST(stc), .I_AT_ZERO_SPEED(zspd), .I_FAULT_ACTIVE(fact), .I_FAULT_CUTS_VOLTAGE(fcut),
    .I_IO_JOG1(1'h0), .I_IO_JOG2(1'h0), .I_IO_JOG_ENABLE(1'h0), .I_PLACE_START(1'h0),
    .O_DRIVE_STATE(state), .O_POWER_ON(pwr), .O_RUN(run), .O_STOP_MODE(stopm), .O_RAMP_MODE(rampm),
    .O_JOG1(jog1), .O_JOG2(jog2), .O_FAULT_RESET(frst), .O_FB_CONTROL_ACTIVE(fba), .O_COMM_FAULT(cflt),
    .O_STATUS_WDOG(wdog));
  initial forever #25 clk = ~clk;
  // ==========================================================================
  // Checking helpers
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input int e, input logic [3:0] g);
    checks_done++;
    if (g !== e[3:0]) begin
      miscompares++;
      $display("[ERR] %s expected %0d seen %0d", n, e, g);
    end
  endtask : chk
  // Send a word, then compare; a negative expectation skips that result
  task automatic go(input logic [15:0] w, input int st, input int sm, input int rm, input int jg);
    logic [3:0] r;
    r = $random(seed);
    echo_q.push_back(w[BIT_WDOG]);
    mdl.send({r, w[11:0]});
    #1;
    chk("echo", echo_q.pop_front(), wdog);
    chk("fb_active", w[BIT_FB_EN] && place == PLACE_FIELDBUS, fba);
    repeat (4) @(posedge clk);
    #1;
    if (st >= 0) chk("state", st, state);
    if (st == 3) chk("run", 1, {pwr, run} == 2'h3);
    if (sm >= 0) chk("stop_mode", sm, stopm);
    if (rm >= 0) chk("ramp_mode", rm, rampm);
    if (jg >= 0) chk("jog", jg, {jog2, jog1});
  endtask : go
  always @(posedge clk) begin
    if (frst === 1'h1) nrst <= nrst + 4'h1;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      miscompares++;
      finish_test();
    end
  end
  // ==========================================================================
  // Scenarios
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    go(16'h0406, -1, -1, -1, -1);
    go(16'h0407, 2, -1, -1, 0);
    go(16'h047F, 3, -1, 0, 0);
    go(16'h046F, 3, -1, 1, 0);
    go(16'h045F, 3, -1, 2, 0);
    go(16'h043F, 3, -1, 3, 0);
    go(16'h044F, 3, -1, 1, 0);
    $display("ramp priority done");
    go(16'h051F, 3, -1, -1, 0);
    zspd <= 1'h0;
    go(16'h050F, 3, -1, -1, 0);
    zspd <= 1'h1;
    go(16'h050F, 3, -1, -1, 1);
    go(16'h070F, -1, 1, -1, 0);
    $display("jog done");
    stc <= 1'h1;
    go(16'h0477, -1, 2, -1, 0);
    stc <= 1'h0;
    go(16'h047F, 3, -1, 0, 0);
    go(16'h047E, 1, 1, -1, 0);
    go(16'h0477, 2, -1, -1, 0);
    go(16'h047F, 3, -1, -1, 0);
    go(16'h047D, 0, 2, -1, 0);
    go(16'h047F, 0, -1, -1, 0);
    go(16'h0476, -1, -1, -1, -1);
    go(16'h0C77, 2, -1, -1, 0);
    go(16'h047F, 3, -1, -1, 0);
    go(16'h047B, -1, 3, -1, 0);
    go(16'h0476, -1, -1, -1, -1);
    go(16'h0477, 2, -1, -1, 0);
    go(16'h047F, 3, -1, -1, 0);
    go(16'h007F, 0, 2, -1, 0);
    $display("stops done");
    place <= 2'h1;
    go(16'h0476, -1, -1, -1, -1);
    go(16'h0477, 0, -1, -1, -1);
    place <= 2'h3;
    go(16'h0476, -1, -1, -1, -1);
    go(16'h0477, 2, -1, -1, -1);
    fact <= 1'h1;
    repeat (5) @(posedge clk);
    #1 chk("state", ST_FAULT, state);
    fact <= 1'h0;
    go(16'h04F7, 0, -1, -1, -1);
    chk("ack_pulses", 1, nrst);
    $display("fault done");
    chk("comm_fault", 0, cflt);
    go(16'h0476, -1, -1, -1, -1);
    go(16'h0477, 2, -1, -1, -1);
    wds <= 16'h0001;
    for (i = 0; i < 45000 && cflt !== 1'h1; i++) @(posedge clk);
    repeat (3) @(posedge clk);
    #1 chk("comm_fault", 1, cflt);
    chk("state", ST_FAULT, state);
    $display("watchdog done");
    finish_test();
  end
endmodule : tb_top
